// [design/cpw_pkg.sv]
/*
 * Constants for the complementary three-phase PWM timer pair: register map,
 * field positions, reset values, mode encodings and the count-clock divider.
 * Assumes a 16-bit timer datapath reached through a plain word-addressed port.
 */
// Function
// - two channels give three complementary non-overlapping pairs
// - mode switches pins and makes counters up/down
// - six pins driven as three complementary pairs
// - period compare is limit minus one
// - combine mode field selects complementary mode
// - period match turns down, underflow turns up
// - matches occur lead, lag, lag, lead
// - compare above period gives 0/100% duty
// - compare A flag set only counting up
// - overflow flag set only on lag underflow
// - buffers copied at up period match, underflow
// - two level select bits invert pair levels
package cpw_pkg;

   localparam int          DATA_W = 16;
   localparam int          ADDR_W = 4;

   // word addresses of the register port
   localparam logic [3:0]  ADDR_START   = 4'h0;   // counter_start_reg
   localparam logic [3:0]  ADDR_TCTRL   = 4'h1;   // timer_control_reg
   localparam logic [3:0]  ADDR_FCTRL   = 4'h2;   // function_control_reg
   localparam logic [3:0]  ADDR_OCTRL   = 4'h3;   // output_control_reg
   localparam logic [3:0]  ADDR_STATUS  = 4'h4;
   localparam logic [3:0]  ADDR_LEAD    = 4'h5;   // lead_counter
   localparam logic [3:0]  ADDR_LAG     = 4'h6;   // lag_counter
   localparam logic [3:0]  ADDR_PERIOD  = 4'h7;   // period_compare
   localparam logic [3:0]  ADDR_PHCMP0  = 4'h8;   // phase1..3 compare at 8..A
   localparam logic [3:0]  ADDR_PHBUF0  = 4'hB;   // phase1..3 buffer at B..D

   // counter_start_reg fields
   localparam int          LEAD_RUN_POS = 0;
   localparam int          LAG_RUN_POS  = 1;
   // timer_control_reg fields (stored, only prescale acts here)
   localparam int          PRESCALE_LSB = 0;     // clock_prescale_sel_lo..hi
   localparam int          PRESCALE_W   = 3;
   localparam int          TCTRL_W      = 7;     // + edge_sel, clear_src_sel
   // function_control_reg fields
   localparam int          COMBINE_LSB  = 0;     // combine_mode_lo/hi
   localparam int          BUFEN_LSB    = 2;     // per-phase buffer enable
   localparam int          FCTRL_W      = 5;
   localparam logic [1:0]  COMBINE_COMPL = 2'h2;
   // output_control_reg fields
   localparam int          INV1_POS     = 0;     // level_invert_pair1
   localparam int          INV23_POS    = 1;     // level_invert_pairs23
   localparam logic [1:0]  OCTRL_RESET  = 2'h3;  // active-high levels
   // status fields
   localparam int          CMPA_FLAG_POS = 0;    // compare_a_flag
   localparam int          OVF_FLAG_POS  = 1;    // overflow_flag
   localparam int          DOWN_POS      = 2;    // read-only direction

   localparam logic [15:0] CMP_RESET    = 16'hFFFF;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_ALL1     = 16'hFFFF;
   localparam int          NPHASE       = 3;

   // prescale select n divides ref_clk by 2**n, select above 3 stops the clock
   localparam int          MAX_PRESCALE = 3;
   localparam int          DIV_W        = 3;

   typedef enum logic [0:0] {
      CPW_UP   = 1'b0,
      CPW_DOWN = 1'b1
   } cpw_dir_t;

endpackage : cpw_pkg

// [design/cpw_core.sv]
/*
 * Complementary three-phase PWM: lead and lag up/down counters, period and
 * phase compares with turn-around buffering, flags and six output pins.
 * Assumes a one-cycle register port (read data one cycle after the strobe)
 * and a single 125 MHz ref_clk with synchronous active-low reset.
 */
`timescale 1ns/10ps
module cpw_core #(
   parameter int NPH = cpw_pkg::NPHASE
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   // register port
   input  wire logic [cpw_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [cpw_pkg::DATA_W-1:0] regWdata,
   input  wire logic                       regWr,
   input  wire logic                       regRd,
   output logic      [cpw_pkg::DATA_W-1:0] regRdata,
   // pwm pins
   output logic                            phase1Out,
   output logic                            phase1OutN,
   output logic                            phase2Out,
   output logic                            phase2OutN,
   output logic                            phase3Out,
   output logic                            phase3OutN,
   output logic                            pwmPinSel,
   // status to the surrounding timer
   output logic                            cmpAFlag,
   output logic                            ovfFlag,
   output logic                            countDown
);
   import cpw_pkg::*;

   typedef struct packed {
      logic [1:0]                  run;
      logic [TCTRL_W-1:0]          tctrl;
      logic [FCTRL_W-1:0]          fctrl;
      logic [1:0]                  octrl;
      logic                        cmpAFlag;
      logic                        ovfFlag;
      cpw_dir_t                    dir;
      logic [DATA_W-1:0]           lead;
      logic [DATA_W-1:0]           lag;
      logic [DATA_W-1:0]           period;
      logic [NPH-1:0][DATA_W-1:0]  phCmp;
      logic [NPH-1:0][DATA_W-1:0]  phBuf;
      logic [NPH-1:0]              posRaw;
      logic [NPH-1:0]              negRaw;
      logic [DIV_W-1:0]            div;
      logic [DATA_W-1:0]           rdata;
   } cpw_state_t;

   cpw_state_t state_ff;
   cpw_state_t nxt_state;

   logic                    modeOn;
   logic                    tick;
   logic                    running;
   logic                    periodMatch;
   logic                    lagUnder;
   logic [PRESCALE_W-1:0]   psel;
   logic [DIV_W-1:0]        divMask;
   logic [NPH-1:0]          pinPos;
   logic [NPH-1:0]          pinNeg;
   logic [NPH-1:0]          invSel;

   ////////////////////////////////////////////////////////////////////////////
   // count clock and turn-around events

   assign modeOn  = state_ff.fctrl[COMBINE_LSB +: 2] == COMBINE_COMPL;
   assign psel    = state_ff.tctrl[PRESCALE_LSB +: PRESCALE_W];
   assign divMask = DIV_W'((1 << psel) - 1);
   // external clock sources are not wired to this block, so they stop counting
   assign tick    = (int'(psel) <= MAX_PRESCALE) && ((state_ff.div & divMask) == '0);
   // both run bits needed: the pair only makes sense counting in lock step
   assign running = modeOn && (&state_ff.run) && tick;

   // match is taken as the counter leaves the matching value
   assign periodMatch = running && state_ff.dir == CPW_UP
                        && state_ff.lead == state_ff.period;
   assign lagUnder    = running && state_ff.dir == CPW_DOWN
                        && state_ff.lag == CNT_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_state = state_ff;
      nxt_state.rdata = '0;
      nxt_state.div = state_ff.div + DIV_W'(1);

      // counters: overshoot one past period, undershoot one below zero
      if (running) begin
         if (state_ff.dir == CPW_UP) begin
            nxt_state.lead = state_ff.lead + DATA_W'(1);
            nxt_state.lag  = state_ff.lag + DATA_W'(1);
         end else begin
            nxt_state.lead = state_ff.lead - DATA_W'(1);
            nxt_state.lag  = state_ff.lag - DATA_W'(1);
         end
      end
      if (periodMatch) begin
         nxt_state.dir = CPW_DOWN;
      end
      if (lagUnder) begin
         nxt_state.dir = CPW_UP;
      end

      // per-phase edges: up lead, up lag, down lag, down lead
      for (int p = 0; p < NPH; p++) begin
         if (running && state_ff.dir == CPW_UP) begin
            if (state_ff.lead == state_ff.phCmp[p]) begin
               nxt_state.negRaw[p] = 1'b0;
            end
            // undershoot value is no count: an all-ones compare would overlap the pair
            if (state_ff.lag == state_ff.phCmp[p] && state_ff.lag != CNT_ALL1) begin
               nxt_state.posRaw[p] = 1'b1;
            end
         end else if (running) begin
            if (state_ff.lag == state_ff.phCmp[p]) begin
               nxt_state.posRaw[p] = 1'b0;
            end
            if (state_ff.lead == state_ff.phCmp[p]) begin
               nxt_state.negRaw[p] = 1'b1;
            end
         end
         // compare above period+1 never matches, so the pair holds still
         if ((periodMatch || lagUnder) && state_ff.fctrl[BUFEN_LSB + p]) begin
            nxt_state.phCmp[p] = state_ff.phBuf[p];
         end
      end

      // out of the mode the pair rests with positive off, negated on
      if (!modeOn) begin
         nxt_state.posRaw = '0;
         nxt_state.negRaw = '1;
         nxt_state.dir    = CPW_UP;
      end

      // sticky flags, set wins over a clear in the same cycle
      if (regWr && regAddr == ADDR_STATUS) begin
         if (!regWdata[CMPA_FLAG_POS]) begin
            nxt_state.cmpAFlag = 1'b0;
         end
         if (!regWdata[OVF_FLAG_POS]) begin
            nxt_state.ovfFlag = 1'b0;
         end
      end
      if (periodMatch) begin
         nxt_state.cmpAFlag = 1'b1;
      end
      if (lagUnder) begin
         nxt_state.ovfFlag = 1'b1;
      end

      // register writes; a software write beats the counter update
      if (regWr) begin
         case (regAddr)
            ADDR_START:  nxt_state.run    = regWdata[1:0];
            ADDR_TCTRL:  nxt_state.tctrl  = regWdata[TCTRL_W-1:0];
            ADDR_FCTRL:  nxt_state.fctrl  = regWdata[FCTRL_W-1:0];
            ADDR_OCTRL:  nxt_state.octrl  = regWdata[1:0];
            ADDR_LEAD:   nxt_state.lead   = regWdata;
            ADDR_LAG:    nxt_state.lag    = regWdata;
            ADDR_PERIOD: nxt_state.period = regWdata;
            default: begin
               for (int p = 0; p < NPH; p++) begin
                  if (regAddr == ADDR_PHCMP0 + ADDR_W'(p)) begin
                     nxt_state.phCmp[p] = regWdata;
                  end
                  if (regAddr == ADDR_PHBUF0 + ADDR_W'(p)) begin
                     nxt_state.phBuf[p] = regWdata;
                  end
               end
            end
         endcase
      end

      // read data, unmapped words read zero
      if (regRd) begin
         case (regAddr)
            ADDR_START:  nxt_state.rdata = DATA_W'(state_ff.run);
            ADDR_TCTRL:  nxt_state.rdata = DATA_W'(state_ff.tctrl);
            ADDR_FCTRL:  nxt_state.rdata = DATA_W'(state_ff.fctrl);
            ADDR_OCTRL:  nxt_state.rdata = DATA_W'(state_ff.octrl);
            ADDR_STATUS: nxt_state.rdata = DATA_W'({state_ff.dir, state_ff.ovfFlag, state_ff.cmpAFlag});
            ADDR_LEAD:   nxt_state.rdata = state_ff.lead;
            ADDR_LAG:    nxt_state.rdata = state_ff.lag;
            ADDR_PERIOD: nxt_state.rdata = state_ff.period;
            default: begin
               for (int p = 0; p < NPH; p++) begin
                  if (regAddr == ADDR_PHCMP0 + ADDR_W'(p)) begin
                     nxt_state.rdata = state_ff.phCmp[p];
                  end
                  if (regAddr == ADDR_PHBUF0 + ADDR_W'(p)) begin
                     nxt_state.rdata = state_ff.phBuf[p];
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_ff.run      <= '0;
         state_ff.tctrl    <= '0;
         state_ff.fctrl    <= '0;
         state_ff.octrl    <= OCTRL_RESET;
         state_ff.cmpAFlag <= 1'b0;
         state_ff.ovfFlag  <= 1'b0;
         state_ff.dir      <= CPW_UP;
         state_ff.lead     <= CNT_RESET;
         state_ff.lag      <= CNT_RESET;
         state_ff.period   <= CMP_RESET;
         state_ff.phCmp    <= {NPH{CMP_RESET}};
         state_ff.phBuf    <= {NPH{CMP_RESET}};
         state_ff.posRaw   <= '0;
         state_ff.negRaw   <= '1;
         state_ff.div      <= '0;
         state_ff.rdata    <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins: level select clear means active-low pair

   always_comb begin
      for (int p = 0; p < NPH; p++) begin
         invSel[p] = (p == 0) ? state_ff.octrl[INV1_POS] : state_ff.octrl[INV23_POS];
         pinPos[p] = invSel[p] ? state_ff.posRaw[p] : ~state_ff.posRaw[p];
         pinNeg[p] = invSel[p] ? state_ff.negRaw[p] : ~state_ff.negRaw[p];
      end
   end

   assign phase1Out  = pinPos[0];
   assign phase1OutN = pinNeg[0];
   assign phase2Out  = pinPos[1];
   assign phase2OutN = pinNeg[1];
   assign phase3Out  = pinPos[2];
   assign phase3OutN = pinNeg[2];
   assign pwmPinSel  = modeOn;
   assign regRdata   = state_ff.rdata;
   assign cmpAFlag   = state_ff.cmpAFlag;
   assign ovfFlag    = state_ff.ovfFlag;
   assign countDown  = state_ff.dir == CPW_DOWN;

endmodule : cpw_core

// [sim/cpw_core_assertions.sv]
/* Checker for cpw_core: pair exclusion, pin select, flags against direction, register port.
   Assumes the bind below and that the controls change only by register-port writes. */
`timescale 1ns/10ps
module cpw_core_assertions
   import cpw_pkg::*;
(
   // clock, reset and register port
   input wire logic                       ref_clk, rstn, regWr, regRd,
   input wire logic [cpw_pkg::ADDR_W-1:0] regAddr,
   input wire logic [cpw_pkg::DATA_W-1:0] regWdata, regRdata,
   // pins and status
   input wire logic                       phase1Out, phase1OutN, phase2Out, phase2OutN, phase3Out, phase3OutN,
   input wire logic                       pwmPinSel, cmpAFlag, ovfFlag, countDown
);
   logic [1:0] levelSel_ff;
   logic [1:0] mode_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   // shadow of the two controls the pins depend on
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         levelSel_ff <= OCTRL_RESET;
         mode_ff <= 2'h0;
      end else if (regWr && regAddr == ADDR_OCTRL) begin
         levelSel_ff <= regWdata[1:0];
      end else if (regWr && regAddr == ADDR_FCTRL) begin
         mode_ff <= regWdata[1:0];
      end
   end
   a_pair1_exclusive: assert property (!(phase1Out == levelSel_ff[0] && phase1OutN == levelSel_ff[0]))
      else $error("pair 1 both active");
   a_pair2_exclusive: assert property (!(phase2Out == levelSel_ff[1] && phase2OutN == levelSel_ff[1]))
      else $error("pair 2 both active");
   a_pair3_exclusive: assert property (!(phase3Out == levelSel_ff[1] && phase3OutN == levelSel_ff[1]))
      else $error("pair 3 both active");
   a_mode_pins: assert property (pwmPinSel == (mode_ff == COMBINE_COMPL))
      else $error("pin select does not follow combine mode");
   a_peak_flag: assert property ($rose(countDown) |-> cmpAFlag)
      else $error("turn down without compare flag");
   a_flag_up_only: assert property ($rose(cmpAFlag) |-> $rose(countDown))
      else $error("compare flag set outside the peak");
   a_trough_flag: assert property ($rose(ovfFlag) |-> $fell(countDown))
      else $error("underflow flag without turn up");
   a_exit_pins: assert property ($fell(pwmPinSel) |=> phase1Out != levelSel_ff[0]
      && phase1OutN == levelSel_ff[0] && phase3OutN == levelSel_ff[1] && !countDown)
      else $error("pins not parked after mode exit");
   a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (regRd && regAddr > ADDR_PHBUF0 + 4'h2 |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");
   a_level_read: assert property (regRd && regAddr == ADDR_OCTRL |=> regRdata == {14'h0000, levelSel_ff})
      else $error("level select read wrong");
   c_peak: cover property ($rose(cmpAFlag));
   c_trough: cover property ($rose(ovfFlag));
   c_exit: cover property ($fell(pwmPinSel));
endmodule : cpw_core_assertions

bind cpw_core cpw_core_assertions i_cpw_core_assertions (.ref_clk(ref_clk), .rstn(rstn), .regWr(regWr),
   .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .phase1Out(phase1Out),
   .phase1OutN(phase1OutN), .phase2Out(phase2Out), .phase2OutN(phase2OutN), .phase3Out(phase3Out),
   .phase3OutN(phase3OutN), .pwmPinSel(pwmPinSel), .cmpAFlag(cmpAFlag), .ovfFlag(ovfFlag), .countDown(countDown));

// [sim/cpw_pin_load.sv]
/* Load on the six pwm pins: counts the cycles each pin spends high.
   Assumes a one-cycle clr pulse from the bench before each measurement. */
`timescale 1ns/10ps
module cpw_pin_load (
   // clock and control
   input  wire logic             ref_clk,
   input  wire logic             clr,
   // pins: pair1 pos/neg, pair2 pos/neg, pair3 pos/neg
   input  wire logic [5:0]       pins,
   // high-cycle counts
   output logic      [5:0][15:0] onCnt
);
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 6; i++) begin
         onCnt[i] <= clr ? 16'h0000 : onCnt[i] + {15'h0000, pins[i]};
      end
   end
endmodule : cpw_pin_load

// [sim/test_cpw_core.sv]
/* Bench for cpw_core: reset map, duty per pair, inversion, buffered update, mode exit.
   Assumes the checker binds itself and the pin load sits on the six pins. */
`timescale 1ns/10ps
module test_cpw_core;
   import cpw_pkg::*;
   // period 9, margin 2, compares 5, 3, 0xFFFF: high cycles over four periods
   localparam logic [5:0][15:0] EXP_HIGH = {16'h0048, 16'h0000, 16'h0010, 16'h0028, 16'h0020, 16'h0018};
   logic             ref_clk = 1'b0;
   logic             rstn = 1'b0;
   logic [3:0]       regAddr = 4'h0;
   logic [15:0]      regWdata = 16'h0000;
   logic             regWr = 1'b0;
   logic             regRd = 1'b0;
   logic             clr = 1'b0;
   logic [15:0]      regRdata;
   wire  [5:0]       pins;
   logic             pwmPinSel, cmpAFlag, ovfFlag, countDown;
   logic [5:0][15:0] onCnt;
   int               failures = 0;
   int               checked = 0;
   always #4 ref_clk = ~ref_clk;
   cpw_core i_cpw_core (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .phase1Out(pins[0]), .phase1OutN(pins[1]), .phase2Out(pins[2]),
      .phase2OutN(pins[3]), .phase3Out(pins[4]), .phase3OutN(pins[5]), .pwmPinSel(pwmPinSel),
      .cmpAFlag(cmpAFlag), .ovfFlag(ovfFlag), .countDown(countDown));
   cpw_pin_load i_cpw_pin_load (.ref_clk(ref_clk), .clr(clr), .pins(pins), .onCnt(onCnt));
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask : rd
   // sel: 0 compare flag, 1 underflow flag, 2 counting down, 3 counting up
   task automatic wait_on(input int sel);
      logic [3:0] s;
      for (int n = 0; n < 100; n++) begin
         @(posedge ref_clk);
         #1;
         s = {!countDown, countDown, ovfFlag, cmpAFlag};
         if (s[sel] === 1'b1) break;
      end
      chk({15'h0000, s[sel]}, 16'h0001);
   endtask : wait_on
   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 15; a++) begin
         rd(a[3:0], (a == 3) ? 16'h0003 : (a >= 7 && a <= 13) ? 16'hFFFF : 16'h0000);
      end
      $display("test reset_map done");
      wr(ADDR_START, 16'h0000);
      wr(ADDR_TCTRL, 16'h0000);
      wr(ADDR_FCTRL, 16'h0006);
      wr(ADDR_LAG, 16'h0000);
      wr(ADDR_LEAD, 16'h0002);
      wr(ADDR_PERIOD, 16'h0009);
      wr(ADDR_PHCMP0, 16'h0005);
      wr(ADDR_PHCMP0 + 4'h1, 16'h0003);
      wr(ADDR_PHCMP0 + 4'h2, 16'hFFFF);
      wr(ADDR_PHBUF0, 16'h0005);
      chk({15'h0000, pwmPinSel}, 16'h0001);
      wr(ADDR_START, 16'h0003);
      wait_on(0);
      chk({15'h0000, countDown}, 16'h0001);
      wait_on(1);
      chk({15'h0000, countDown}, 16'h0000);
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (72) @(posedge ref_clk);
      #1;
      for (int p = 0; p < 6; p++) begin
         chk(onCnt[p], EXP_HIGH[p]);
      end
      $display("test duty done");
      wr(ADDR_OCTRL, 16'h0000);
      rd(ADDR_OCTRL, 16'h0000);
      chk({14'h0000, pins[5:4]}, 16'h0001);
      wr(ADDR_OCTRL, 16'h0003);
      $display("test invert done");
      // parked beyond range, so the band cautions at both turn-arounds hold
      wr(ADDR_PHBUF0, 16'h0020);
      wait_on(2);
      wait_on(3);
      rd(ADDR_PHCMP0, 16'h0020);
      rd(ADDR_PHCMP0 + 4'h1, 16'h0003);
      $display("test buffer done");
      wr(ADDR_START, 16'h0000);
      wr(ADDR_FCTRL, 16'h0000);
      rd(ADDR_STATUS, 16'h0003);
      chk({9'h000, pwmPinSel, pins}, 16'h002A);
      wr(ADDR_STATUS, 16'h0003);
      rd(ADDR_STATUS, 16'h0003);
      wr(ADDR_STATUS, 16'h0000);
      rd(ADDR_STATUS, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      wr(ADDR_LAG, 16'h0000);
      rd(ADDR_LAG, 16'h0000);
      $display("test mode_exit done");
      // stopped count clock: counters must hold their start values
      wr(ADDR_TCTRL, 16'h0004);
      wr(ADDR_FCTRL, 16'h0002);
      wr(ADDR_LEAD, 16'h0002);
      wr(ADDR_START, 16'h0003);
      repeat (20) @(posedge ref_clk);
      rd(ADDR_LEAD, 16'h0002);
      rd(ADDR_LAG, 16'h0000);
      $display("test stopped_clock done");
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
endmodule : test_cpw_core
